//--- hw/ippc_ctrl.sv
/*
  Interrupt enable, four-level priority, in-service tracking and external pin
  trigger logic, with an APB register slave.
  Assumes synchronous pin inputs, a core that pulses core_ack only while
  irq_req is high and core_reti once per finished handler.
*/
// Local design decision: the APB slave port.
`timescale 1ns/1ps

// Contract
// - priority code 11 is level 3 (highest), 10 level 2, 01 level 1.
// - code 00 is level 0, lowest; all priority bits reset to zero.
// - timer two priority uses bit 5 of both group a registers.
// - serial a priority uses bit 4 of both group a registers.
// - timer one priority uses bit 3 of both group a registers.
// - pin b priority uses bit 2 of both group a registers.
// - timer zero priority uses bit 1 of both group a registers.
// - pin a priority uses bit 0 of both group a registers.
// - serial b priority uses bit 5 of both group b registers.
// - spi priority uses bit 4 of both group b registers.
// - converter/touch priority uses bit 3 of both group b registers.
// - pin c priority uses bit 2 of both group b registers.
// - port one change priority uses bit 1 of both group b registers.
// - timer three priority uses bit 0 of both group b registers.
// - pins a and b trigger on falling edge or low level, selectable.
// - pin c triggers only on a falling edge.
// - any port one pin change raises the port change interrupt; the code counts only pins set in wake_mask.
// - all three pins and port one changes can wake from stop.
// - only a strictly higher level preempts a running handler.
// - global enable zero masks all; one defers to each source enable.
// - pin c flag sets on fall always; cleared by entry or writing zero.
module ippc_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_pin_a,
  input wire logic ext_pin_b,
  input wire logic ext_pin_c,
  input wire logic [7:0] port_one_pins,
  input wire logic timer_zero_req,
  input wire logic timer_one_req,
  input wire logic timer_two_req,
  input wire logic timer_three_req,
  input wire logic serial_a_req,
  input wire logic serial_b_req,
  input wire logic spi_req,
  input wire logic conv_touch_req,
  input wire logic core_ack,
  input wire logic core_reti,
  output logic irq_req,
  output logic [3:0] irq_id,
  output logic [1:0] irq_level,
  output logic stop_wake
);

  typedef struct packed {
    logic [7:0] main_en;
    logic [5:0] aux_en;
    logic [5:0] prio_lo_a;
    logic [5:0] prio_hi_a;
    logic [5:0] prio_lo_b;
    logic [5:0] prio_hi_b;
    logic [1:0] trig_mode;
    logic [1:0] edge_ab;
    logic flag_c;
    logic flag_port;
    logic [7:0] wake_mask;
    logic pin_a_prev;
    logic pin_b_prev;
    logic pin_c_prev;
    logic [7:0] port_prev;
    logic [3:0] in_service;
    logic irq_req;
    logic [3:0] irq_id;
    logic [1:0] irq_level;
    logic stop_wake;
    logic [31:0] prdata;
  } ippc_state_t;

  ippc_state_t s_q;
  ippc_state_t s_d;
  logic [9:0] idx;
  logic mapped;
  logic wr_en;
  logic [11:0] pend;
  logic [11:0] gated;
  logic [11:0] prio_hi_all;
  logic [11:0] prio_lo_all;
  logic fall_a;
  logic fall_b;
  logic fall_c;
  logic port_change;

  //////////////////////////////////////////////////////////////////////////////
  // bus decode

  // zero-wait slave; read data is captured in the setup cycle
  assign idx = paddr[11:2];
  assign mapped = (paddr[1:0] == 2'h0) &&
    (idx == ippc_pkg::IDX_TRIG || idx == ippc_pkg::IDX_FLAG || idx == ippc_pkg::IDX_WAKE ||
     idx == ippc_pkg::IDX_MAIN || idx == ippc_pkg::IDX_AUX || idx == ippc_pkg::IDX_PRIO_LO_A ||
     idx == ippc_pkg::IDX_PRIO_HI_A || idx == ippc_pkg::IDX_PRIO_LO_B ||
     idx == ippc_pkg::IDX_PRIO_HI_B || idx == ippc_pkg::IDX_STATUS);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign wr_en = psel && penable && pwrite && mapped;

  //////////////////////////////////////////////////////////////////////////////
  // source requests

  // pins are sampled synchronously, so a one-cycle history gives the edges
  assign fall_a = s_q.pin_a_prev && !ext_pin_a;
  assign fall_b = s_q.pin_b_prev && !ext_pin_b;
  assign fall_c = s_q.pin_c_prev && !ext_pin_c;
  assign port_change = |((s_q.port_prev ^ port_one_pins) & s_q.wake_mask);

  // index order doubles as the tie break between equal levels
  assign pend[0] = s_q.trig_mode[0] ? s_q.edge_ab[0] : !ext_pin_a;
  assign pend[1] = timer_zero_req;
  assign pend[2] = s_q.trig_mode[1] ? s_q.edge_ab[1] : !ext_pin_b;
  assign pend[3] = timer_one_req;
  assign pend[4] = serial_a_req;
  assign pend[5] = timer_two_req;
  assign pend[6] = timer_three_req;
  assign pend[7] = s_q.flag_port;
  assign pend[8] = s_q.flag_c;
  assign pend[9] = conv_touch_req;
  assign pend[10] = spi_req;
  assign pend[11] = serial_b_req;

  // group a holds sources 0..5, group b sources 6..11, bit for bit
  assign prio_hi_all = {s_q.prio_hi_b, s_q.prio_hi_a};
  assign prio_lo_all = {s_q.prio_lo_b, s_q.prio_lo_a};
  assign gated = pend & {s_q.aux_en, s_q.main_en[5:0]} & {12{s_q.main_en[ippc_pkg::MAIN_GLOBAL_BIT]}};

  //////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic found;
    logic [3:0] best_id;
    logic [1:0] best_lvl;
    logic [1:0] lvl;
    logic any_active;
    logic [1:0] cur_lvl;
    logic clr_sw_a;
    logic clr_sw_b;
    logic clr_sw_c;
    logic clr_sw_port;
    logic ack_a;
    logic ack_b;
    logic ack_c;
    logic [31:0] rd;
    found = 1'b0;
    best_id = ippc_pkg::RST_ID;
    best_lvl = ippc_pkg::LEVEL_0;
    lvl = ippc_pkg::LEVEL_0;
    any_active = 1'b0;
    cur_lvl = ippc_pkg::LEVEL_0;
    clr_sw_a = 1'b0;
    clr_sw_b = 1'b0;
    clr_sw_c = 1'b0;
    clr_sw_port = 1'b0;
    ack_a = 1'b0;
    ack_b = 1'b0;
    ack_c = 1'b0;
    rd = 32'h0;
    s_d = s_q;
    s_d.pin_a_prev = ext_pin_a;
    s_d.pin_b_prev = ext_pin_b;
    s_d.pin_c_prev = ext_pin_c;
    s_d.port_prev = port_one_pins;

    // highest pending level wins; walking downward lets lower indices win ties
    for (int i = ippc_pkg::N_SRC - 1; i >= 0; i--) begin
      lvl = {prio_hi_all[i], prio_lo_all[i]};
      if (gated[i] && (!found || lvl >= best_lvl)) begin
        found = 1'b1;
        best_id = 4'(i);
        best_lvl = lvl;
      end
    end

    // level of the running handler is the highest in-service bit
    for (int j = 0; j < 4; j++) begin
      if (s_q.in_service[j]) begin
        any_active = 1'b1;
        cur_lvl = 2'(j);
      end
    end

    // strictly higher only; the ack cycle drops the request so it is not taken twice
    s_d.irq_req = found && (!any_active || best_lvl > cur_lvl) && !core_ack;
    s_d.irq_id = best_id;
    s_d.irq_level = best_lvl;

    // entering a handler stacks its level; return pops the top one
    ack_a = core_ack && s_q.irq_id == ippc_pkg::SRC_PIN_A;
    ack_b = core_ack && s_q.irq_id == ippc_pkg::SRC_PIN_B;
    ack_c = core_ack && s_q.irq_id == ippc_pkg::SRC_PIN_C;
    if (core_ack) begin
      s_d.in_service = s_q.in_service | (4'h1 << s_q.irq_level);
    end else if (core_reti && any_active) begin
      s_d.in_service = s_q.in_service & ~(4'h1 << cur_lvl);
    end

    // register writes take effect at the access edge
    if (wr_en) begin
      case (idx)
        ippc_pkg::IDX_MAIN: s_d.main_en = pwdata[7:0] & ippc_pkg::MAIN_WR_MASK;
        ippc_pkg::IDX_AUX: s_d.aux_en = pwdata[5:0];
        ippc_pkg::IDX_PRIO_LO_A: s_d.prio_lo_a = pwdata[5:0];
        ippc_pkg::IDX_PRIO_HI_A: s_d.prio_hi_a = pwdata[5:0];
        ippc_pkg::IDX_PRIO_LO_B: s_d.prio_lo_b = pwdata[5:0];
        ippc_pkg::IDX_PRIO_HI_B: s_d.prio_hi_b = pwdata[5:0];
        ippc_pkg::IDX_WAKE: s_d.wake_mask = pwdata[7:0];
        ippc_pkg::IDX_TRIG: begin
          s_d.trig_mode = {pwdata[ippc_pkg::TRIG_MODE_B_BIT], pwdata[ippc_pkg::TRIG_MODE_A_BIT]};
          clr_sw_a = !pwdata[ippc_pkg::TRIG_FLAG_A_BIT];
          clr_sw_b = !pwdata[ippc_pkg::TRIG_FLAG_B_BIT];
        end
        ippc_pkg::IDX_FLAG: begin
          clr_sw_c = !pwdata[ippc_pkg::FLAG_PIN_C_BIT];
          clr_sw_port = !pwdata[ippc_pkg::FLAG_PORT_BIT];
        end
        default: ;
      endcase
    end

    // flags: a new event in the clearing cycle survives, set wins
    s_d.edge_ab[0] = (s_q.edge_ab[0] && !clr_sw_a && !ack_a) || fall_a;
    s_d.edge_ab[1] = (s_q.edge_ab[1] && !clr_sw_b && !ack_b) || fall_b;
    s_d.flag_c = (s_q.flag_c && !clr_sw_c && !ack_c) || fall_c;
    s_d.flag_port = (s_q.flag_port && !clr_sw_port) || port_change;

    // stop wake ignores the global enable; port wake ignores its interrupt enable
    s_d.stop_wake = (s_q.main_en[0] && pend[0]) || (s_q.main_en[2] && pend[2]) ||
      (s_q.aux_en[ippc_pkg::AUX_PIN_C_EN_BIT] && s_q.flag_c) || s_q.flag_port;

    // read mux; reserved bits read zero
    case (idx)
      ippc_pkg::IDX_MAIN: rd[7:0] = s_q.main_en;
      ippc_pkg::IDX_AUX: rd[5:0] = s_q.aux_en;
      ippc_pkg::IDX_PRIO_LO_A: rd[5:0] = s_q.prio_lo_a;
      ippc_pkg::IDX_PRIO_HI_A: rd[5:0] = s_q.prio_hi_a;
      ippc_pkg::IDX_PRIO_LO_B: rd[5:0] = s_q.prio_lo_b;
      ippc_pkg::IDX_PRIO_HI_B: rd[5:0] = s_q.prio_hi_b;
      ippc_pkg::IDX_WAKE: rd[7:0] = s_q.wake_mask;
      ippc_pkg::IDX_TRIG: rd[3:0] = {s_q.edge_ab[1], s_q.trig_mode[1], s_q.edge_ab[0], s_q.trig_mode[0]};
      ippc_pkg::IDX_FLAG: rd[2:1] = {s_q.flag_c, s_q.flag_port};
      ippc_pkg::IDX_STATUS: rd[10:0] = {s_q.irq_req, s_q.irq_level, s_q.irq_id, s_q.in_service};
      default: rd = 32'h0;
    endcase
    if (psel && !penable && !pwrite && mapped) begin
      s_d.prdata = rd;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // state register

  // all priority bits clear at reset, so every source starts at level 0
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q.main_en <= ippc_pkg::RST_BYTE;
      s_q.aux_en <= ippc_pkg::RST_GROUP;
      s_q.prio_lo_a <= ippc_pkg::RST_GROUP;
      s_q.prio_hi_a <= ippc_pkg::RST_GROUP;
      s_q.prio_lo_b <= ippc_pkg::RST_GROUP;
      s_q.prio_hi_b <= ippc_pkg::RST_GROUP;
      s_q.trig_mode <= 2'h0;
      s_q.edge_ab <= 2'h0;
      s_q.flag_c <= 1'b0;
      s_q.flag_port <= 1'b0;
      s_q.wake_mask <= ippc_pkg::RST_BYTE;
      s_q.pin_a_prev <= 1'b1;
      s_q.pin_b_prev <= 1'b1;
      s_q.pin_c_prev <= 1'b1;
      s_q.port_prev <= ippc_pkg::RST_BYTE;
      s_q.in_service <= 4'h0;
      s_q.irq_req <= 1'b0;
      s_q.irq_id <= ippc_pkg::RST_ID;
      s_q.irq_level <= ippc_pkg::RST_LEVEL;
      s_q.stop_wake <= 1'b0;
      s_q.prdata <= 32'h0;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata = s_q.prdata;
  assign irq_req = s_q.irq_req;
  assign irq_id = s_q.irq_id;
  assign irq_level = s_q.irq_level;
  assign stop_wake = s_q.stop_wake;

  //////////////////////////////////////////////////////////////////////////////
  // checks

  // each source's level comes from its own bit pair in the right group
  for (genvar g = 0; g < ippc_pkg::N_SRC; g++) begin : g_map
    localparam int GB = g % ippc_pkg::GROUP_W;
    if (g < ippc_pkg::GROUP_W) begin : g_a
      src_prio_map_a: assert property (@(posedge pclk) disable iff (!presetn)
        s_q.irq_req && s_q.irq_id == 4'(g) |-> s_q.irq_level == $past({s_q.prio_hi_a[GB], s_q.prio_lo_a[GB]}))
        else $error("group a priority mismatch");
    end else begin : g_b
      src_prio_map_a: assert property (@(posedge pclk) disable iff (!presetn)
        s_q.irq_req && s_q.irq_id == 4'(g) |-> s_q.irq_level == $past({s_q.prio_hi_b[GB], s_q.prio_lo_b[GB]}))
        else $error("group b priority mismatch");
    end
  end

  sequence fall_edge_mode_s;
    s_q.trig_mode[0] && s_q.pin_a_prev && !ext_pin_a && !core_ack;
  endsequence

  sequence pin_c_fall_s;
    s_q.pin_c_prev && !ext_pin_c;
  endsequence

  preempt_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_q.irq_req |-> (s_q.in_service >> s_q.irq_level) == 4'h0)
    else $error("request not above running level");

  ack_drops_req_a: assert property (@(posedge pclk) disable iff (!presetn)
    core_ack |=> !s_q.irq_req && s_q.in_service[$past(s_q.irq_level)])
    else $error("ack did not stack level");

  global_mask_a: assert property (@(posedge pclk) disable iff (!presetn)
    !s_q.main_en[ippc_pkg::MAIN_GLOBAL_BIT] ##1 !s_q.main_en[ippc_pkg::MAIN_GLOBAL_BIT] |-> !s_q.irq_req)
    else $error("request while globally masked");

  aux_enable_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_q.irq_req && s_q.irq_id == ippc_pkg::SRC_SPI |-> $past(s_q.aux_en[4]))
    else $error("spi request while disabled");

  edge_trigger_a: assert property (@(posedge pclk) disable iff (!presetn)
    fall_edge_mode_s ##1 s_q.trig_mode[0] |-> pend[0])
    else $error("pin a edge lost");

  pin_c_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    pin_c_fall_s |=> s_q.flag_c ##1 (s_q.stop_wake || !s_q.aux_en[ippc_pkg::AUX_PIN_C_EN_BIT]))
    else $error("pin c flag or wake missing");

  pin_c_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    core_ack && s_q.irq_id == ippc_pkg::SRC_PIN_C && !fall_c |=> !s_q.flag_c)
    else $error("pin c flag not cleared on entry");

  port_change_a: assert property (@(posedge pclk) disable iff (!presetn)
    port_change |=> s_q.flag_port ##1 s_q.stop_wake)
    else $error("port change not flagged or no wake");

  reti_pop_a: assert property (@(posedge pclk) disable iff (!presetn)
    core_reti && !core_ack && s_q.in_service != 4'h0 |=> s_q.in_service < $past(s_q.in_service))
    else $error("return did not pop a level");

  port_wake_free_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_q.flag_port |=> s_q.stop_wake)
    else $error("port flag gave no wake");

  level_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
    !s_q.trig_mode[0] && !ext_pin_a && s_q.main_en[0] && s_q.main_en[ippc_pkg::MAIN_GLOBAL_BIT] &&
      s_q.in_service == 4'h0 && !core_ack |=> s_q.irq_req)
    else $error("low pin a gave no request");

endmodule

//--- hw/ippc_pkg.sv
/*
  Constants shared by the interrupt priority and pin trigger block: register
  indices, field positions, reset values and source numbering.
  Assumes an APB slave that places register index N at byte address 4*N.
*/
package ippc_pkg;
  // register indices; byte address is four times the index
  localparam logic [9:0] IDX_TRIG = 10'h088;
  localparam logic [9:0] IDX_FLAG = 10'h095;
  localparam logic [9:0] IDX_WAKE = 10'h096;
  localparam logic [9:0] IDX_MAIN = 10'h0a8;
  localparam logic [9:0] IDX_AUX = 10'h0a9;
  localparam logic [9:0] IDX_PRIO_LO_A = 10'h0b8;
  localparam logic [9:0] IDX_PRIO_HI_A = 10'h0b9;
  localparam logic [9:0] IDX_PRIO_LO_B = 10'h0ba;
  localparam logic [9:0] IDX_PRIO_HI_B = 10'h0bb;
  localparam logic [9:0] IDX_STATUS = 10'h0c0;

  // field positions
  localparam int MAIN_GLOBAL_BIT = 7;
  localparam logic [7:0] MAIN_WR_MASK = 8'hbf;
  localparam int TRIG_MODE_A_BIT = 0;
  localparam int TRIG_FLAG_A_BIT = 1;
  localparam int TRIG_MODE_B_BIT = 2;
  localparam int TRIG_FLAG_B_BIT = 3;
  localparam int FLAG_PORT_BIT = 1;
  localparam int FLAG_PIN_C_BIT = 2;
  localparam int AUX_PIN_C_EN_BIT = 2;
  localparam int GROUP_W = 6;
  localparam int N_SRC = 12;

  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [5:0] RST_GROUP = 6'h00;
  localparam logic [1:0] RST_LEVEL = 2'h0;
  localparam logic [3:0] RST_ID = 4'h0;

  // source numbers; also the polling order among equal levels
  localparam logic [3:0] SRC_PIN_A = 4'h0;
  localparam logic [3:0] SRC_TIMER_ZERO = 4'h1;
  localparam logic [3:0] SRC_PIN_B = 4'h2;
  localparam logic [3:0] SRC_TIMER_ONE = 4'h3;
  localparam logic [3:0] SRC_SERIAL_A = 4'h4;
  localparam logic [3:0] SRC_TIMER_TWO = 4'h5;
  localparam logic [3:0] SRC_TIMER_THREE = 4'h6;
  localparam logic [3:0] SRC_PORT_CHANGE = 4'h7;
  localparam logic [3:0] SRC_PIN_C = 4'h8;
  localparam logic [3:0] SRC_CONV_TOUCH = 4'h9;
  localparam logic [3:0] SRC_SPI = 4'ha;
  localparam logic [3:0] SRC_SERIAL_B = 4'hb;

  // priority codes formed as {high bit, low bit}
  localparam logic [1:0] LEVEL_3 = 2'h3;
  localparam logic [1:0] LEVEL_2 = 2'h2;
  localparam logic [1:0] LEVEL_1 = 2'h1;
  localparam logic [1:0] LEVEL_0 = 2'h0;
endpackage

//--- tb/ippc_core_model.sv
/*
  Behavioural processor core for the interrupt block: acknowledges a
  request after a chosen wait and returns from a handler on command.
  Assumes the bench pulses reti_go for one clock while no ack is due.
*/
`timescale 1ns/1ps
module ippc_core_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic irq_req,
  input wire logic [3:0] irq_id,
  input wire logic ack_en,
  input wire logic [3:0] ack_wait,
  input wire logic reti_go,
  output logic core_ack,
  output logic core_reti,
  output logic [3:0] acked_id
);
  logic [3:0] cnt_q;

  // ack only a request seen high, one pulse at a time; a slow core lets the
  // request sit, so a stronger one may overtake it meanwhile
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_ack <= 1'b0;
      core_reti <= 1'b0;
      acked_id <= 4'h0;
      cnt_q <= 4'h0;
    end else begin
      core_reti <= reti_go;
      if (core_ack || !irq_req || !ack_en) begin
        core_ack <= 1'b0;
        cnt_q <= 4'h0;
      end else if (cnt_q >= ack_wait) begin
        core_ack <= 1'b1;
        acked_id <= irq_id;
      end else begin
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end
endmodule

//--- tb/ippc_bench.sv
/*
  Self-checking bench for the interrupt priority and pin trigger block.
  Assumes ippc_pkg, ippc_ctrl and the core model are compiled before it.
*/
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin mismatches++; \
  $display("unexpected at %0t got %0h exp %0h", $time, (a), (e)); end end
module interrupt_priority_pin_ctrl_bench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, irq_req, stop_wake, core_ack, core_reti, er;
  logic [3:0] irq_id, acked_id;
  logic [1:0] irq_level;
  logic pa = 1'b1, pb = 1'b1, pc = 1'b1, ack_en = 1'b0, reti_go = 1'b0;
  logic [3:0] ack_wait = 4'h0;
  logic [7:0] p1 = 8'h00;
  logic [11:0] rq = 12'h000;
  int mismatches = 0;
  int total_checks = 0;
  int cyc = 0;
  int unsigned seed = 81;
  int rm[int];
  int ps[8] = '{1, 3, 4, 5, 6, 9, 10, 11};
  logic [9:0] ri[5] = '{ippc_pkg::IDX_AUX, ippc_pkg::IDX_PRIO_LO_A, ippc_pkg::IDX_PRIO_HI_A,
    ippc_pkg::IDX_PRIO_LO_B, ippc_pkg::IDX_PRIO_HI_B};

  ippc_ctrl ippc_ctrl_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_pin_a(pa), .ext_pin_b(pb), .ext_pin_c(pc), .port_one_pins(p1),
    .timer_zero_req(rq[1]), .timer_one_req(rq[3]), .timer_two_req(rq[5]),
    .timer_three_req(rq[6]), .serial_a_req(rq[4]), .serial_b_req(rq[11]), .spi_req(rq[10]),
    .conv_touch_req(rq[9]), .core_ack(core_ack), .core_reti(core_reti), .irq_req(irq_req),
    .irq_id(irq_id), .irq_level(irq_level), .stop_wake(stop_wake));
  ippc_core_model ippc_core_model_inst (.pclk(pclk), .presetn(presetn), .irq_req(irq_req),
    .irq_id(irq_id), .ack_en(ack_en), .ack_wait(ack_wait), .reti_go(reti_go),
    .core_ack(core_ack), .core_reti(core_reti), .acked_id(acked_id));

  ////////////////////////////////////////////////////////////////////////////
  // clock, and a ceiling well above the few hundred cycles the tests need
  always #5 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc++;
    if (cyc > 20000) begin
      mismatches++;
      complete_run();
    end
  end

  function automatic int unsigned xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // expected level of a source: {high bit, low bit} of its group and position
  function automatic logic [1:0] lvl(input int s);
    int h, l;
    h = s < 6 ? rm[int'(ippc_pkg::IDX_PRIO_HI_A)] : rm[int'(ippc_pkg::IDX_PRIO_HI_B)];
    l = s < 6 ? rm[int'(ippc_pkg::IDX_PRIO_LO_A)] : rm[int'(ippc_pkg::IDX_PRIO_LO_B)];
    return {h[s % 6], l[s % 6]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // one apb transfer, entered just after a rising edge; held until pready
  task automatic apb(input logic w, input logic [9:0] i, input logic [7:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [9:0] i, input int v);
    apb(1'b1, i, v[7:0]);
    rm[int'(i)] = v & ((i == ippc_pkg::IDX_MAIN) ? 32'hbf : 32'h3f);
  endtask

  task automatic rc(input logic [9:0] i, input logic [31:0] e);
    apb(1'b0, i, 8'h00);
    `CHK(rd, e)
  endtask

  // bounded wait on irq_req (w=0) or stop_wake (w=1)
  task automatic wq(input bit w, input logic v);
    int n;
    n = 0;
    while ((w ? stop_wake : irq_req) !== v && n < 40) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 40) `CHK(w ? stop_wake : irq_req, v)
  endtask

  task automatic reti();
    reti_go <= 1'b1;
    @(posedge pclk);
    reti_go <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask

  task automatic done(input string s);
    $display("test %0s done", s);
  endtask

  task complete_run();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    foreach (ri[k]) rm[int'(ri[k])] = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // registers: reset values, random write and read back, unmapped address
    foreach (ri[k]) rc(ri[k], 32'h0);
    foreach (ri[k]) begin
      wr(ri[k], int'(xs() & 32'hff));
      rc(ri[k], 32'(rm[int'(ri[k])]));
    end
    apb(1'b1, 10'h3ff, 8'h5a);
    `CHK(er, 1'b1)
    done("registers");
    // each peripheral source reports the level built from its bit pair
    wr(ippc_pkg::IDX_MAIN, 32'hbf);
    wr(ippc_pkg::IDX_AUX, 32'h3f);
    repeat (2) begin
      for (int k = 1; k < 5; k++) wr(ri[k], int'(xs() & 32'h3f));
      foreach (ps[k]) begin
        rq[ps[k]] <= 1'b1;
        wq(1'b0, 1'b1);
        `CHK(irq_id, 4'(ps[k]))
        `CHK(irq_level, lvl(ps[k]))
        rq <= 12'h000;
        wq(1'b0, 1'b0);
      end
    end
    done("priority");
    // global enable off masks the timer three request until set again
    wr(ippc_pkg::IDX_MAIN, 32'h3f);
    rq[6] <= 1'b1;
    repeat (8) @(posedge pclk);
    `CHK(irq_req, 1'b0)
    wr(ippc_pkg::IDX_MAIN, 32'hbf);
    wq(1'b0, 1'b1);
    `CHK(irq_id, ippc_pkg::SRC_TIMER_THREE)
    rq <= 12'h000;
    wq(1'b0, 1'b0);
    done("global");
    // nesting: equal level waits, higher level preempts, slow core
    wr(ippc_pkg::IDX_PRIO_LO_A, 32'h0a);
    wr(ippc_pkg::IDX_PRIO_HI_A, 32'h20);
    ack_wait <= 4'h3;
    ack_en <= 1'b1;
    rq[1] <= 1'b1;
    wq(1'b0, 1'b1);
    wq(1'b0, 1'b0);
    `CHK(acked_id, ippc_pkg::SRC_TIMER_ZERO)
    rq <= 12'h008;
    repeat (8) @(posedge pclk);
    `CHK(irq_req, 1'b0)
    rq[5] <= 1'b1;
    wq(1'b0, 1'b1);
    `CHK(irq_level, ippc_pkg::LEVEL_2)
    wq(1'b0, 1'b0);
    rq[5] <= 1'b0;
    reti();
    reti();
    wq(1'b0, 1'b1);
    `CHK(irq_id, ippc_pkg::SRC_TIMER_ONE)
    wq(1'b0, 1'b0);
    rq <= 12'h000;
    reti();
    done("preempt");
    // pin c: edge flag, stop wake without global, clearing rules
    ack_en <= 1'b0;
    ack_wait <= 4'h0;
    wr(ippc_pkg::IDX_MAIN, 32'h00);
    wr(ippc_pkg::IDX_AUX, 32'h00);
    wr(ippc_pkg::IDX_PRIO_LO_B, 32'h04);
    wr(ippc_pkg::IDX_PRIO_HI_B, 32'h04);
    pc <= 1'b0;
    @(posedge pclk);
    rc(ippc_pkg::IDX_FLAG, 32'h4);
    `CHK(stop_wake, 1'b0)
    wr(ippc_pkg::IDX_AUX, 32'h04);
    wq(1'b1, 1'b1);
    `CHK(irq_req, 1'b0)
    wr(ippc_pkg::IDX_FLAG, 32'hff);
    rc(ippc_pkg::IDX_FLAG, 32'h4);
    wr(ippc_pkg::IDX_FLAG, 32'hfb);
    rc(ippc_pkg::IDX_FLAG, 32'h0);
    wq(1'b1, 1'b0);
    pc <= 1'b1;
    wr(ippc_pkg::IDX_MAIN, 32'h80);
    ack_en <= 1'b1;
    pc <= 1'b0;
    wq(1'b0, 1'b1);
    `CHK(irq_id, ippc_pkg::SRC_PIN_C)
    `CHK(irq_level, ippc_pkg::LEVEL_3)
    wq(1'b0, 1'b0);
    rc(ippc_pkg::IDX_FLAG, 32'h0);
    repeat (8) @(posedge pclk);
    `CHK(irq_req, 1'b0)
    rc(ippc_pkg::IDX_STATUS, 32'h8);
    pc <= 1'b1;
    reti();
    done("pin c");
    // port one change: masked pins only, wake without its enable
    wr(ippc_pkg::IDX_AUX, 32'h00);
    wr(ippc_pkg::IDX_PRIO_HI_B, 32'h00);
    wr(ippc_pkg::IDX_PRIO_LO_B, 32'h02);
    wr(ippc_pkg::IDX_WAKE, 32'h08);
    p1 <= 8'h10;
    @(posedge pclk);
    rc(ippc_pkg::IDX_FLAG, 32'h0);
    p1 <= 8'h18;
    wq(1'b1, 1'b1);
    `CHK(irq_req, 1'b0)
    rc(ippc_pkg::IDX_FLAG, 32'h2);
    wr(ippc_pkg::IDX_FLAG, 32'hfd);
    wq(1'b1, 1'b0);
    wr(ippc_pkg::IDX_AUX, 32'h02);
    p1 <= 8'h10;
    wq(1'b0, 1'b1);
    `CHK(irq_id, ippc_pkg::SRC_PORT_CHANGE)
    `CHK(irq_level, lvl(7))
    wq(1'b0, 1'b0);
    wr(ippc_pkg::IDX_FLAG, 32'hfd);
    reti();
    done("port change");
    // pin a in level mode re-requests; pin b in edge mode fires once
    wr(ippc_pkg::IDX_PRIO_LO_A, 32'h05);
    wr(ippc_pkg::IDX_PRIO_HI_A, 32'h04);
    wr(ippc_pkg::IDX_TRIG, 32'h04);
    wr(ippc_pkg::IDX_MAIN, 32'h85);
    pa <= 1'b0;
    wq(1'b0, 1'b1);
    `CHK(irq_level, lvl(0))
    wq(1'b0, 1'b0);
    reti();
    wq(1'b0, 1'b1);
    `CHK(irq_id, ippc_pkg::SRC_PIN_A)
    wq(1'b0, 1'b0);
    pa <= 1'b1;
    reti();
    pb <= 1'b0;
    wq(1'b0, 1'b1);
    `CHK(irq_level, lvl(2))
    wq(1'b0, 1'b0);
    reti();
    repeat (8) @(posedge pclk);
    `CHK(irq_req, 1'b0)
    // pin a in edge mode fires once although the pin stays low
    wr(ippc_pkg::IDX_TRIG, 32'h05);
    pa <= 1'b0;
    wq(1'b0, 1'b1);
    `CHK(irq_id, ippc_pkg::SRC_PIN_A)
    wq(1'b0, 1'b0);
    reti();
    repeat (8) @(posedge pclk);
    `CHK(irq_req, 1'b0)
    done("pins a b");
    complete_run();
  end
endmodule
